// *** pcmr_pkg.sv ***
// Shared constants and types for the receive data output stage.
package pcmr_pkg;
    // Channel count and output buffering.
    localparam int NCH = 8;
    localparam int FIFO_DEPTH = 32;
    // Clock period and master clock idle timeout.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MCLK_IDLE_NS = 1000;
    localparam int MCLK_IDLE_CYC = (MCLK_IDLE_NS * 1000) / CLK_PERIOD_PS;
    localparam int IDLE_W = 16;
    // Bit positions inside the synchroniser vector.
    localparam int SY_MCLK = 0;
    localparam int SY_SEL = 1;
    localparam int SY_HOST = 2;
    localparam int SY_LINE = 3;
    // Register port layout.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_LOS = 4'h2;
    localparam int CTRL_AIS_BIT = 0;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_MODE_LSB = 1;
    localparam int STAT_HOST_BIT = 3;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
    // Output modes, Gray coded along tristate, clock recovery, data recovery.
    typedef enum logic [1:0] {
        PCMR_MODE_TRI = 2'h0,
        PCMR_MODE_CLKREC = 2'h1,
        PCMR_MODE_DATAREC = 2'h3
    } pcmr_mode_t;
endpackage : pcmr_pkg

// *** pcmr_fifo_if.sv ***
// Carrier between the capture stage and the output FIFO.
`timescale 1ns/1ps
interface pcmr_fifo_if #(parameter int W = 16);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
    modport store (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
endinterface : pcmr_fifo_if

// *** pcmr_fifo.sv ***
// Synchronous FIFO holding captured bit words between capture and output.
`timescale 1ns/1ps
module pcmr_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    pcmr_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr_r;
    logic [AW:0] rptr_r;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // Extra pointer bit tells full from empty when the indices meet.
    assign empty = (wptr_r == rptr_r);
    assign full = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    assign f.in_ready = ~full;
    assign f.out_valid = ~empty;
    assign f.out_data = mem[rptr_r[AW-1:0]];
    assign push = ce && f.in_valid && ~full;
    assign pop = ce && f.out_ready && ~empty;

    // Storage array; no reset needed since reads are gated by empty.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r[AW-1:0]] <= f.in_data;
        end
    end

    // Pointer advance on accepted transfers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule : pcmr_fifo

// *** pcmr_rx_out.sv ***
// Receive data output stage: pin sync, mode detect, capture, FIFO and output drive.
`timescale 1ns/1ps
// Functional notes
// (R1) Eight channels, each with positive and negative outputs.
// (R2) Host mode: alarm pattern replaces data during LOS.
// (R3) Hardware mode: data keeps flowing during LOS.
// (R4) Running master clock gives NRZ clock-recovery outputs.
// (R5) Negative line pulse drives negative output high.
// (R6) Positive line pulse drives positive output high.
// (R7) Outputs valid on the selected receive clock edge.
// (R8) Master clock held high gives RZ outputs.
// (R9) Master clock held low tristates data outputs.
// (R10) Data recovery: receive clock is XOR of outputs.
// (R11) During LOS receive clock carries master clock.
// (R12) Positive and negative never high in one bit.
module pcmr_rx_out #(
    parameter int NUM_CH = pcmr_pkg::NCH,
    parameter int FIFO_DEPTH = pcmr_pkg::FIFO_DEPTH,
    parameter int MCLK_IDLE = pcmr_pkg::MCLK_IDLE_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic mclk,
    input wire logic clock_edge_select,
    input wire logic host_mode,
    input wire logic [NUM_CH-1:0] line_in_tip,
    input wire logic [NUM_CH-1:0] line_in_ring,
    input wire logic [NUM_CH-1:0] los_in,
    input wire logic [pcmr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pcmr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pcmr_pkg::DATA_W-1:0] reg_rdata,
    output logic [NUM_CH-1:0] rx_positive_out,
    output logic [NUM_CH-1:0] rx_negative_out,
    output logic rx_data_oe_n,
    output logic [NUM_CH-1:0] rx_clk_out,
    output logic rx_clk_oe_n
);
    import pcmr_pkg::*;

    // Every check below runs on the system clock and sleeps through reset.
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    localparam int SW = SY_LINE + 3 * NUM_CH;
    localparam int SY_RING = SY_LINE + NUM_CH;
    localparam int SY_LOS = SY_LINE + 2 * NUM_CH;
    localparam logic [IDLE_W-1:0] IDLE_LIM = IDLE_W'(MCLK_IDLE);

    // A mark counts on one rail only when the other rail is quiet.
    function automatic logic [NUM_CH-1:0] sole_mark(input logic [NUM_CH-1:0] a,
                                                  input logic [NUM_CH-1:0] b);
        sole_mark = a & ~b;
    endfunction : sole_mark

    logic [SW-1:0] raw;
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [SW-1:0] s3_r;
    logic [SW-1:0] filt_r;
    logic mclk_f;
    logic sel_f;
    logic host_f;
    logic [NUM_CH-1:0] tip_f;
    logic [NUM_CH-1:0] ring_f;
    logic [NUM_CH-1:0] los_f;
    logic mclk_d_r;
    logic mclk_rise;
    logic mclk_fall;
    logic [IDLE_W-1:0] idle_cnt_r;
    pcmr_mode_t mode_r;
    pcmr_mode_t mode_nxt;
    pcmr_mode_t out_mode_r;
    logic [NUM_CH-1:0] tip_d_r;
    logic [NUM_CH-1:0] ring_d_r;
    logic [NUM_CH-1:0] tip_rise;
    logic [NUM_CH-1:0] ring_rise;
    logic [NUM_CH-1:0] pend_pos_r;
    logic [NUM_CH-1:0] pend_neg_r;
    logic [NUM_CH-1:0] clean_pos;
    logic [NUM_CH-1:0] clean_neg;
    logic [NUM_CH-1:0] ais_sel;
    logic [NUM_CH-1:0] cap_pos;
    logic [NUM_CH-1:0] cap_neg;
    logic boundary;
    logic ais_phase_r;
    logic [2*NUM_CH-1:0] word_r;
    logic word_valid_r;
    logic ovf_r;
    logic upd;
    logic pop;
    logic [NUM_CH-1:0] nrz_pos_r;
    logic [NUM_CH-1:0] nrz_neg_r;
    logic [NUM_CH-1:0] rz_pos;
    logic [NUM_CH-1:0] rz_neg;
    logic [DATA_W-1:0] ctrl_r;
    logic ais_en;
    logic [NUM_CH-1:0] los_q_r;
    logic mclk_q_r;

    pcmr_fifo_if #(.W(2 * NUM_CH)) fif ();

    // Every pin-side input passes three flops before anyone looks at it.
    assign raw = {los_in, line_in_ring, line_in_tip, host_mode, clock_edge_select, mclk};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else if (ce) begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A level change is accepted only once stages two and three agree.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filt_r <= '0;
        end else if (ce) begin
            filt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
        end
    end

    assign mclk_f = filt_r[SY_MCLK];
    assign sel_f = filt_r[SY_SEL];
    assign host_f = filt_r[SY_HOST];
    assign tip_f = filt_r[SY_LINE +: NUM_CH];
    assign ring_f = filt_r[SY_RING +: NUM_CH];
    assign los_f = filt_r[SY_LOS +: NUM_CH];

    // Master clock edge detection on the filtered level.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mclk_d_r <= 1'b0;
        end else if (ce) begin
            mclk_d_r <= mclk_f;
        end
    end

    assign mclk_rise = mclk_f & ~mclk_d_r;
    assign mclk_fall = ~mclk_f & mclk_d_r;

    // Idle timer: a master clock with no edge for the timeout counts as held.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_r <= IDLE_LIM;
        end else if (ce) begin
            if (mclk_rise || mclk_fall) begin
                idle_cnt_r <= '0;
            end else if (idle_cnt_r < IDLE_LIM) begin
                idle_cnt_r <= idle_cnt_r + 1'b1;
            end
        end
    end

    // Mode follows the master clock: running, held high or held low.
    always_comb begin
        if (idle_cnt_r < IDLE_LIM) begin
            mode_nxt = PCMR_MODE_CLKREC; // R4
        end else if (mclk_f) begin
            mode_nxt = PCMR_MODE_DATAREC; // R8
        end else begin
            mode_nxt = PCMR_MODE_TRI; // R9
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= PCMR_MODE_TRI;
        end else if (ce) begin
            mode_r <= mode_nxt;
        end
    end

    // Line pulse detection; each rising pulse is one mark on its rail.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tip_d_r <= '0;
            ring_d_r <= '0;
        end else if (ce) begin
            tip_d_r <= tip_f;
            ring_d_r <= ring_f;
        end
    end

    assign tip_rise = tip_f & ~tip_d_r;
    assign ring_rise = ring_f & ~ring_d_r;
    assign boundary = mclk_rise && (mode_r == PCMR_MODE_CLKREC);

    // Marks seen in a bit period are held until the boundary; a pulse at the boundary opens the next bit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_pos_r <= '0;
            pend_neg_r <= '0;
        end else if (ce) begin
            pend_pos_r <= boundary ? tip_rise : (pend_pos_r | tip_rise);
            pend_neg_r <= boundary ? ring_rise : (pend_neg_r | ring_rise);
        end
    end

    // A bit with marks on both rails is not a legal bipolar bit and reads as a space.
    assign clean_pos = sole_mark(pend_pos_r, pend_neg_r); // R12 R6
    assign clean_neg = sole_mark(pend_neg_r, pend_pos_r); // R12 R5

    // Alarm substitution only in host mode with the enable set; hardware mode passes data.
    assign ais_en = ctrl_r[CTRL_AIS_BIT];
    assign ais_sel = {NUM_CH{host_f & ais_en}} & los_f; // R2 R3
    assign cap_pos = (ais_sel & {NUM_CH{ais_phase_r}}) | (~ais_sel & clean_pos); // R2
    assign cap_neg = (ais_sel & {NUM_CH{~ais_phase_r}}) | (~ais_sel & clean_neg); // R2

    // Alarm pattern alternates mark polarity bit by bit, all ones on the line.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ais_phase_r <= 1'b0;
        end else if (ce && boundary) begin
            ais_phase_r <= ~ais_phase_r;
        end
    end

    // Captured word waits here until the FIFO takes it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word_r <= '0;
            word_valid_r <= 1'b0;
        end else if (ce) begin
            if (boundary) begin
                word_r <= {cap_neg, cap_pos};
                word_valid_r <= 1'b1;
            end else if (fif.in_ready) begin
                word_valid_r <= 1'b0;
            end
        end
    end

    // Overrun flag: a new bit while the old one is still refused. Set beats a clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovf_r <= 1'b0;
        end else if (ce) begin
            if (boundary && word_valid_r && !fif.in_ready) begin
                ovf_r <= 1'b1;
            end else if (reg_wr && reg_addr == ADDR_STAT && reg_wdata[STAT_OVF_BIT]) begin
                ovf_r <= 1'b0;
            end
        end
    end

    assign fif.in_valid = word_valid_r;
    assign fif.in_data = word_r;

    // Output updates on the edge opposite the one the framer samples.
    assign upd = sel_f ? mclk_fall : mclk_rise; // R7
    assign pop = upd && (mode_r == PCMR_MODE_CLKREC);
    assign fif.out_ready = pop;

    pcmr_fifo #(
        .W(2 * NUM_CH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .f(fif)
    );

    // NRZ hold registers; an empty FIFO at an update gives a space.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nrz_pos_r <= '0;
            nrz_neg_r <= '0;
        end else if (ce && pop) begin
            nrz_pos_r <= fif.out_valid ? fif.out_data[NUM_CH-1:0] : '0; // R4 R7
            nrz_neg_r <= fif.out_valid ? fif.out_data[2*NUM_CH-1:NUM_CH] : '0; // R4 R7
        end
    end

    // Data recovery passes pulses straight through as return-to-zero marks.
    assign rz_pos = sole_mark(tip_f, ring_f); // R8 R6 R12
    assign rz_neg = sole_mark(ring_f, tip_f); // R8 R5 R12

    // Output drive per mode; all outputs come from flops.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_positive_out <= '0;
            rx_negative_out <= '0;
            rx_clk_out <= '0;
            rx_data_oe_n <= 1'b1;
            rx_clk_oe_n <= 1'b1;
            out_mode_r <= PCMR_MODE_TRI;
            los_q_r <= '0;
            mclk_q_r <= 1'b0;
        end else if (ce) begin
            out_mode_r <= mode_r;
            los_q_r <= los_f;
            mclk_q_r <= mclk_f;
            unique case (mode_r)
                PCMR_MODE_CLKREC: begin
                    rx_positive_out <= nrz_pos_r; // R1 R4
                    rx_negative_out <= nrz_neg_r; // R1 R4
                    rx_clk_out <= {NUM_CH{mclk_f}}; // R11
                    rx_data_oe_n <= 1'b0;
                    rx_clk_oe_n <= 1'b0;
                end
                PCMR_MODE_DATAREC: begin
                    rx_positive_out <= rz_pos; // R1 R8
                    rx_negative_out <= rz_neg; // R1 R8
                    rx_clk_out <= (los_f & {NUM_CH{mclk_f}}) | (~los_f & (rz_pos ^ rz_neg)); // R10 R11
                    rx_data_oe_n <= 1'b0;
                    rx_clk_oe_n <= 1'b0;
                end
                default: begin
                    rx_positive_out <= '0;
                    rx_negative_out <= '0;
                    rx_clk_out <= '0;
                    rx_data_oe_n <= 1'b1; // R9
                    rx_clk_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Control register: alarm insert enable.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce && reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_r <= reg_wdata;
        end
    end

    // Read data stand for exactly the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= RDATA_IDLE;
        end else if (ce) begin
            reg_rdata <= RDATA_IDLE;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_CTRL: reg_rdata <= ctrl_r;
                    ADDR_STAT: begin
                        reg_rdata <= RDATA_IDLE;
                        reg_rdata[STAT_OVF_BIT] <= ovf_r;
                        reg_rdata[STAT_MODE_LSB +: 2] <= mode_r;
                        reg_rdata[STAT_HOST_BIT] <= host_f;
                    end
                    ADDR_LOS: reg_rdata <= DATA_W'(los_f);
                    default: reg_rdata <= RDATA_IDLE;
                endcase
            end
        end
    end

    no_both_high_a: assert property (~|(rx_positive_out & rx_negative_out)) // R12
        else $error("Positive and negative outputs high together");
    tristate_oe_a: assert property (ce && mode_r == PCMR_MODE_TRI |=> rx_data_oe_n && rx_positive_out == '0) // R9
        else $error("Data outputs not released in tristate mode");
    xor_clock_a: assert property (out_mode_r == PCMR_MODE_DATAREC |-> // R10
            ((rx_clk_out ^ (rx_positive_out ^ rx_negative_out)) & ~los_q_r) == '0)
        else $error("Receive clock is not the XOR of the data outputs");
    los_clock_a: assert property (out_mode_r != PCMR_MODE_TRI |-> // R11
            ((rx_clk_out ^ {NUM_CH{mclk_q_r}}) & los_q_r) == '0)
        else $error("Receive clock does not carry master clock during LOS");
    pos_pulse_a: assert property (ce && mode_r == PCMR_MODE_DATAREC |=> // R6
            rx_positive_out == $past(tip_f & ~ring_f))
        else $error("Positive output does not follow positive pulse");
    neg_pulse_a: assert property (ce && mode_r == PCMR_MODE_DATAREC |=> // R5
            rx_negative_out == $past(ring_f & ~tip_f))
        else $error("Negative output does not follow negative pulse");
    nrz_hold_a: assert property (ce && mode_r == PCMR_MODE_CLKREC && !pop ##1 // R4
            ce && mode_r == PCMR_MODE_CLKREC |=> $stable(rx_positive_out) && $stable(rx_negative_out))
        else $error("NRZ output changed inside a bit period");
    edge_select_a: assert property ($changed(nrz_pos_r) || $changed(nrz_neg_r) |-> // R7
            $past(sel_f ? mclk_fall : mclk_rise))
        else $error("Output updated on the wrong clock edge");
    ais_insert_a: assert property (ce && boundary && host_f && ais_en |=> // R2
            ((word_r[NUM_CH-1:0] | word_r[2*NUM_CH-1:NUM_CH]) & $past(los_f)) == $past(los_f))
        else $error("Alarm pattern missing on a channel in LOS");
    hw_passthru_a: assert property (ce && boundary && !host_f |=> // R3
            word_r == $past({clean_neg, clean_pos}))
        else $error("Hardware mode altered captured data");
endmodule : pcmr_rx_out

// *** pcmr_framer_model.sv ***
// Framer model that samples one channel of the receive outputs on the selected clock edge.
`timescale 1ns/1ps
module pcmr_framer_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic edge_sel,
    input wire logic [2:0] watch_ch,
    input wire logic [7:0] rx_clk,
    input wire logic [7:0] rx_pos,
    input wire logic [7:0] rx_neg,
    input wire logic oe_n,
    output int pos_hits,
    output int neg_hits,
    output int clk_edges
);
    logic clk_d_r;
    // Data are taken only on the chosen receive clock edge, so a late update shows as a missed bit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_d_r <= 1'b0;
            pos_hits <= 0;
            neg_hits <= 0;
            clk_edges <= 0;
        end else begin
            clk_d_r <= rx_clk[watch_ch];
            if (!oe_n && rx_clk[watch_ch] === edge_sel && clk_d_r !== edge_sel) begin
                pos_hits <= pos_hits + (rx_pos[watch_ch] === 1'b1 ? 1 : 0);
                neg_hits <= neg_hits + (rx_neg[watch_ch] === 1'b1 ? 1 : 0);
                clk_edges <= clk_edges + 1;
            end
        end
    end
endmodule : pcmr_framer_model

// *** testbench.sv ***
// Self-checking testbench for the receive data output stage.
`timescale 1ns/1ps
module testbench;
    import pcmr_pkg::*;
    localparam int IDLE_SMALL = 30;
    logic clk, resetn, ce, mclk, mclk_run, mclk_hold, mclk_ph, edge_sel, host_mode, reg_wr, reg_rd;
    logic [7:0] tip, ring, los, reg_wdata, reg_rdata, rx_pos, rx_neg, rx_clk, rd;
    logic [3:0] reg_addr;
    logic [2:0] watch_ch;
    logic rx_data_oe_n, rx_clk_oe_n;
    int pos_hits, neg_hits, clk_edges, num_errors, n_tests, seed, cyc_count, ch, p0, n0, e0, k;

    pcmr_rx_out #(.MCLK_IDLE(IDLE_SMALL)) dut_u (.clk(clk), .resetn(resetn), .ce(ce), .mclk(mclk),
        .clock_edge_select(edge_sel), .host_mode(host_mode), .line_in_tip(tip), .line_in_ring(ring),
        .los_in(los), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_positive_out(rx_pos), .rx_negative_out(rx_neg),
        .rx_data_oe_n(rx_data_oe_n), .rx_clk_out(rx_clk), .rx_clk_oe_n(rx_clk_oe_n));

    pcmr_framer_model framer_u (.clk(clk), .resetn(resetn), .edge_sel(edge_sel), .watch_ch(watch_ch),
        .rx_clk(rx_clk), .rx_pos(rx_pos), .rx_neg(rx_neg), .oe_n(rx_data_oe_n),
        .pos_hits(pos_hits), .neg_hits(neg_hits), .clk_edges(clk_edges));

    // System clock, 5 ns period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Master clock at 125 ns, offset so that it never lines up with the system clock.
    initial begin
        mclk_ph = 1'b0;
        #1.3;
        forever #62.5 mclk_ph = ~mclk_ph;
    end
    assign mclk = mclk_run ? mclk_ph : mclk_hold;

    // A hang is cut short well past the expected run length.
    always @(posedge clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 30000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // Mode field of the status register as the bench expects it.
    function automatic logic [15:0] mode_exp(input pcmr_mode_t m);
        return {14'h0, m};
    endfunction : mode_exp

    // Static on purpose: the channel index is used in nonblocking assignments.
    task pulse(input int c, input logic p, input logic n, input int w);
        @(posedge clk);
        tip[c] <= p;
        ring[c] <= n;
        repeat (w) @(posedge clk);
        tip[c] <= 1'b0;
        ring[c] <= 1'b0;
    endtask : pulse

    // A one-rail line pulse in clock recovery must give exactly one sampled mark on its own rail; a pulse on both rails gives none.
    task automatic bit_check(input int c, input logic p, input logic n);
        watch_ch <= c[2:0];
        wait_clk(3);
        p0 = pos_hits;
        n0 = neg_hits;
        pulse(c, p, n, 6);
        wait_clk(120);
        chk(16'(pos_hits - p0), {15'h0, p & ~n});
        chk(16'(neg_hits - n0), {15'h0, n & ~p});
    endtask : bit_check

    initial begin
        seed = 43;
        num_errors = 0;
        n_tests = 0;
        cyc_count = 0;
        ce = 1'b1;
        resetn = 1'b0;
        mclk_run = 1'b0;
        mclk_hold = 1'b0;
        edge_sel = 1'b0;
        host_mode = 1'b0;
        tip = 8'h00;
        ring = 8'h00;
        los = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        watch_ch = 3'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        wait_clk(IDLE_SMALL + 20);
        chk({14'h0, rx_data_oe_n, rx_clk_oe_n}, 16'h3);
        chk({rx_neg, rx_pos}, 16'h0);
        reg_read(ADDR_STAT, rd);
        chk({14'h0, rd[2:1]}, mode_exp(PCMR_MODE_TRI));
        $display("test reset_tristate done");

        // Register port: storage, unmapped place, input mirror.
        k = $random(seed);
        reg_write(ADDR_CTRL, k[7:0] & 8'hFE);
        reg_read(ADDR_CTRL, rd);
        chk({8'h0, rd}, {8'h0, k[7:0] & 8'hFE});
        reg_read(4'hF, rd);
        chk({8'h0, rd}, 16'h0);
        @(posedge clk);
        los <= k[15:8];
        wait_clk(8);
        reg_read(ADDR_LOS, rd);
        chk({8'h0, rd}, {8'h0, k[15:8]});
        @(posedge clk);
        los <= 8'h00;
        $display("test registers done");

        // Clock recovery with both sampling edges, random channels and rails.
        mclk_run = 1'b1;
        wait_clk(80);
        reg_read(ADDR_STAT, rd);
        chk({14'h0, rd[2:1]}, mode_exp(PCMR_MODE_CLKREC));
        chk({15'h0, rx_data_oe_n}, 16'h0);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            edge_sel <= s[0];
            wait_clk(80);
            for (int i = 0; i < 4; i++) begin
                ch = $unsigned($random(seed)) % NCH;
                k = $random(seed);
                bit_check(ch, k[0], ~k[0]);
            end
            bit_check(ch, 1'b1, 1'b1);
        end
        $display("test clock_recovery done");

        // Hardware mode keeps data flowing in loss of signal; the master clock feeds the receive clock.
        ch = $unsigned($random(seed)) % NCH;
        @(posedge clk);
        los[ch] <= 1'b1;
        wait_clk(10);
        e0 = clk_edges;
        bit_check(ch, 1'b1, 1'b0);
        chk({15'h0, (clk_edges - e0) >= 4}, 16'h1);
        $display("test hardware_los done");

        // Host mode with the alarm enabled fills every bit period with a mark.
        reg_write(ADDR_CTRL, 8'h01);
        @(posedge clk);
        host_mode <= 1'b1;
        watch_ch <= ch[2:0];
        wait_clk(80);
        reg_read(ADDR_STAT, rd);
        chk({8'h0, rd}, {12'h0, 1'b1, PCMR_MODE_CLKREC, 1'b0});
        p0 = pos_hits;
        n0 = neg_hits;
        wait_clk(200);
        chk({15'h0, (pos_hits - p0 + neg_hits - n0) >= 6}, 16'h1);
        reg_write(ADDR_CTRL, 8'h00);
        @(posedge clk);
        los <= 8'h00;
        host_mode <= 1'b0;
        wait_clk(80);
        $display("test host_alarm done");

        // Data recovery: return-to-zero outputs and the XOR pseudo clock.
        mclk_hold = 1'b1;
        mclk_run = 1'b0;
        wait_clk(IDLE_SMALL + 40);
        reg_read(ADDR_STAT, rd);
        chk({14'h0, rd[2:1]}, mode_exp(PCMR_MODE_DATAREC));
        ch = $unsigned($random(seed)) % NCH;
        @(posedge clk);
        ring[ch] <= 1'b1;
        for (k = 0; k < 20 && rx_neg[ch] !== 1'b1; k++) begin
            wait_clk(1);
        end
        wait_clk(3);
        chk({13'h0, rx_clk[ch], rx_neg[ch], rx_pos[ch]}, 16'h6);
        // With the clock enable low the outputs must hold although the pulse has ended.
        @(posedge clk);
        ce <= 1'b0;
        ring[ch] <= 1'b0;
        wait_clk(10);
        chk({13'h0, rx_clk[ch], rx_neg[ch], rx_pos[ch]}, 16'h6);
        @(posedge clk);
        ce <= 1'b1;
        wait_clk(20);
        chk({13'h0, rx_clk[ch], rx_neg[ch], rx_pos[ch]}, 16'h0);
        $display("test data_recovery done");

        // Master clock held low puts the outputs back in high impedance.
        mclk_hold = 1'b0;
        wait_clk(IDLE_SMALL + 40);
        chk({14'h0, rx_data_oe_n, rx_clk_oe_n}, 16'h3);
        $display("test tristate done");
        conclude();
    end
endmodule : testbench
